// ### design/txbp_consts.vh
// Register offsets, field positions and timing constants of the transmit blanking and guard block.
`ifndef TXBP_CONSTS_VH
`define TXBP_CONSTS_VH
`define TXBP_ADDR_PAGE       12'h008
`define TXBP_ADDR_IRQ_EN_A   12'h021
`define TXBP_ADDR_IRQ_EN_B   12'h022
`define TXBP_ADDR_IRQ_ST_A   12'h025
`define TXBP_ADDR_IRQ_ST_B   12'h026
`define TXBP_ADDR_PD_MASK    12'h012
`define TXBP_ADDR_GUARD_SEL  12'h013
`define TXBP_ADDR_SEQ_CFG    12'h11F
`define TXBP_ADDR_RISE0      12'h121
`define TXBP_ADDR_RISE1      12'h122
`define TXBP_ADDR_FALL0      12'h123
`define TXBP_ADDR_FALL1      12'h124
`define TXBP_ADDR_UP_LO      12'h140
`define TXBP_ADDR_UP_HI      12'h141
`define TXBP_ADDR_DN_LO      12'h142
`define TXBP_ADDR_DN_HI      12'h143
`define TXBP_ADDR_BLANK_ST   12'h147
`define TXBP_ADDR_GAIN_LO    12'h148
`define TXBP_ADDR_GAIN_HI    12'h149
`define TXBP_BIT_PWR_IRQ     7
`define TXBP_BIT_BLANK_IRQ   5
`define TXBP_BIT_SEL_PWR     6
`define TXBP_BIT_SEL_TX      5
`define TXBP_BIT_SEL_SW      3
`define TXBP_BIT_SW_GUARD    2
`define TXBP_BIT_INVERT      2
`define TXBP_DELAY_UNIT      5
`define TXBP_PWRUP_NS        35000
`define TXBP_CLK_NS          100
`define TXBP_PWRUP_CYC       ((`TXBP_PWRUP_NS + `TXBP_CLK_NS - 1) / `TXBP_CLK_NS)
`define TXBP_ST_HELD         2'h0
`define TXBP_ST_DOWN         2'h1
`define TXBP_ST_UP           2'h2
`define TXBP_ST_NORMAL       2'h3
`define TXBP_GAIN_RST        16'h8000
`endif

// ### design/txbp_top.v
// Transmit blanking and guard-output logic for two DAC pairs with its register port.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "txbp_consts.vh"

module txbp_top #(
   parameter PWRUP_CYC = `TXBP_PWRUP_CYC
) (
   input wire clock_in, // 10 MHz clock.
   input wire rstn_in, // Asynchronous reset, active low.
   input wire [11:0] addr_in, // Register address.
   input wire [7:0] wdata_in, // Register write data.
   input wire wr_in, // Write strobe.
   input wire rd_in, // Read strobe.
   output reg [7:0] rdata_out, // Read data, cycle after strobe.
   input wire [1:0] transmit_enable_in, // Per-pair transmit enable pins.
   input wire [1:0] power_over_in, // Per-pair power detector over threshold.
   input wire sync_rotate_in, // One-cycle pulse from sync logic on rotation.
   output reg [1:0] guard_output_pin_out, // Per-pair guard pins.
   output reg [1:0] pair_powerdown_out, // Per-pair DAC power down.
   output reg [1:0] data_hold_out, // Per-pair hold and flush datapath.
   output reg [31:0] gain_out, // Per-pair ramped gain, pair B high half.
   output wire irq_n_out // Interrupt, active low.
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   reg [1:0] page_ff;
   reg [7:0] irq_en_ff [0:1];
   reg [7:0] irq_src_ff [0:1];
   reg [7:0] mask_ff;
   reg [7:0] sel_ff [0:1];
   reg [7:0] cfg_ff [0:1];
   reg [7:0] rise0_ff [0:1];
   reg [7:0] rise1_ff [0:1];
   reg [7:0] fall0_ff [0:1];
   reg [7:0] fall1_ff [0:1];
   reg [15:0] up_ff [0:1];
   reg [15:0] dn_ff [0:1];
   reg [15:0] gset_ff [0:1];

   // ----------------------------------------------------------------
   // Per-pair sequencing state
   // ----------------------------------------------------------------
   reg [1:0] txs1_ff, txs2_ff, txd_ff;
   reg [1:0] pws1_ff, pws2_ff, pwd_ff;
   reg [1:0] txg_ff, txg_d_ff;
   reg [1:0] bst_ff [0:1];
   reg [1:0] rot_ff;
   reg [1:0] done_ff;
   reg [1:0] dcnt_ff [0:1];
   reg [12:0] cnt_ff [0:1];
   reg [15:0] pwcnt_ff [0:1];
   reg [15:0] gain_ff [0:1];

   // Delay in cycles for one counter value.
   function [12:0] dly;
      input [7:0] v;
      begin
         dly = {v, 5'h00};
      end
   endfunction

   // Page register selects which pair the paged registers reach; pair A when page is 1.
   // Any other page value reaches pair B, so a stray page write never hits both pairs.
   wire pg = (page_ff == 2'h1);
   wire any_src = |(irq_src_ff[0] | irq_src_ff[1]);
   assign irq_n_out = ~any_src;

   integer p;

   // ----------------------------------------------------------------
   // Register writes, events and sequencers
   // ----------------------------------------------------------------
   // Everything shares one process so each register has one driver.
   always @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         page_ff <= 2'h1;
         mask_ff <= 8'h00;
         txs1_ff <= 2'h0; txs2_ff <= 2'h0; txd_ff <= 2'h0;
         pws1_ff <= 2'h0; pws2_ff <= 2'h0; pwd_ff <= 2'h0;
         txg_ff <= 2'h0; txg_d_ff <= 2'h0; rot_ff <= 2'h0; done_ff <= 2'h0;
         guard_output_pin_out <= 2'h0;
         pair_powerdown_out <= 2'h0;
         data_hold_out <= 2'h3;
         gain_out <= 32'h0000_0000;
         for (p = 0; p < 2; p = p + 1) begin
            irq_en_ff[p] <= 8'h00; irq_src_ff[p] <= 8'h00;
            sel_ff[p] <= 8'h00; cfg_ff[p] <= 8'h50;
            rise0_ff[p] <= 8'h00; rise1_ff[p] <= 8'h00;
            fall0_ff[p] <= 8'h12; fall1_ff[p] <= 8'h00;
            up_ff[p] <= 16'h0010; dn_ff[p] <= 16'h0010;
            gset_ff[p] <= `TXBP_GAIN_RST;
            bst_ff[p] <= `TXBP_ST_HELD; dcnt_ff[p] <= 2'h0;
            cnt_ff[p] <= 13'h0000; pwcnt_ff[p] <= 16'h0000; gain_ff[p] <= 16'h0000;
         end
      end else begin
         // Pins cross into the clock domain through two flops.
         txs1_ff <= transmit_enable_in; txs2_ff <= txs1_ff; txd_ff <= txs2_ff;
         pws1_ff <= power_over_in; pws2_ff <= pws1_ff; pwd_ff <= pws2_ff;
         txg_d_ff <= txg_ff;
         if (wr_in) begin
            if (addr_in == `TXBP_ADDR_PAGE) page_ff <= wdata_in[1:0];
            else if (addr_in == `TXBP_ADDR_PD_MASK) mask_ff <= wdata_in;
         end
         for (p = 0; p < 2; p = p + 1) begin
            // Paged writes reach the pair picked by the page register.
            if (wr_in && (pg ? (p == 0) : (p == 1))) begin
               if (addr_in == `TXBP_ADDR_GUARD_SEL) sel_ff[p] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_SEQ_CFG) cfg_ff[p] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_RISE0) rise0_ff[p] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_RISE1) rise1_ff[p] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_FALL0) fall0_ff[p] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_FALL1) fall1_ff[p] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_UP_LO) up_ff[p][7:0] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_UP_HI) up_ff[p][15:8] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_DN_LO) dn_ff[p][7:0] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_DN_HI) dn_ff[p][15:8] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_GAIN_LO) gset_ff[p][7:0] <= wdata_in;
               else if (addr_in == `TXBP_ADDR_GAIN_HI) gset_ff[p][15:8] <= wdata_in;
            end
            if (wr_in && addr_in == (p == 0 ? `TXBP_ADDR_IRQ_EN_A : `TXBP_ADDR_IRQ_EN_B))
               irq_en_ff[p] <= wdata_in;
            // Write one clears; a new event in the same cycle wins over the clear.
            if (wr_in && addr_in == (p == 0 ? `TXBP_ADDR_IRQ_ST_A : `TXBP_ADDR_IRQ_ST_B))
               irq_src_ff[p] <= irq_src_ff[p] & ~wdata_in;
            if (!irq_en_ff[p][`TXBP_BIT_PWR_IRQ])
               irq_src_ff[p][`TXBP_BIT_PWR_IRQ] <= 1'b0;
            else if (pws2_ff[p] && !pwd_ff[p])
               irq_src_ff[p][`TXBP_BIT_PWR_IRQ] <= 1'b1;
            if (!irq_en_ff[p][`TXBP_BIT_BLANK_IRQ])
               irq_src_ff[p][`TXBP_BIT_BLANK_IRQ] <= 1'b0;
            else if (done_ff[p])
               irq_src_ff[p][`TXBP_BIT_BLANK_IRQ] <= 1'b1;

            // Transmit-enable sequencer: a delay chain of up to three counters per edge.
            // Each pair uses its own enable pin, so one pair can blank alone.
            if (txs2_ff[p] != txd_ff[p]) begin
               dcnt_ff[p] <= 2'h0;
               cnt_ff[p] <= 13'h0000;
               if (!txs2_ff[p] && mask_ff[p]) pair_powerdown_out[p] <= 1'b1;
               if (txs2_ff[p]) begin
                  pair_powerdown_out[p] <= 1'b0;
                  pwcnt_ff[p] <= mask_ff[p] ? PWRUP_CYC[15:0] : 16'h0000;
               end
            end else if (txs2_ff[p] != txg_ff[p]) begin
               // Rise uses 0..3 counters, fall always at least one.
               if (txs2_ff[p] ? (dcnt_ff[p] >= cfg_ff[p][5:4])
                              : (dcnt_ff[p] >= cfg_ff[p][7:6] && dcnt_ff[p] != 2'h0))
                  txg_ff[p] <= txs2_ff[p];
               else if (cnt_ff[p] + 13'h0001 >= dly(txs2_ff[p] ?
                        (dcnt_ff[p] == 2'h0 ? rise0_ff[p] : rise1_ff[p]) :
                        (dcnt_ff[p] == 2'h0 ? fall0_ff[p] : fall1_ff[p]))) begin
                  cnt_ff[p] <= 13'h0000;
                  dcnt_ff[p] <= dcnt_ff[p] + 2'h1;
               end else
                  cnt_ff[p] <= cnt_ff[p] + 13'h0001;
            end
            if (pwcnt_ff[p] != 16'h0000 && txs2_ff[p] == txd_ff[p])
               pwcnt_ff[p] <= pwcnt_ff[p] - 16'h0001;

            // Blanking sequencer.
            if (sync_rotate_in && bst_ff[p] == `TXBP_ST_NORMAL) rot_ff[p] <= 1'b1;
            done_ff[p] <= 1'b0;
            case (bst_ff[p])
               `TXBP_ST_NORMAL: begin
                  if ((txg_d_ff[p] && !txg_ff[p]) || (sync_rotate_in && txg_ff[p])) begin
                     bst_ff[p] <= `TXBP_ST_DOWN;
                     data_hold_out[p] <= 1'b1;
                  end else
                     gain_ff[p] <= gset_ff[p];
               end
               `TXBP_ST_DOWN: begin
                  if (gain_ff[p] <= dn_ff[p]) begin
                     gain_ff[p] <= 16'h0000;
                     bst_ff[p] <= `TXBP_ST_HELD;
                     done_ff[p] <= 1'b1;
                  end else
                     gain_ff[p] <= gain_ff[p] - dn_ff[p];
               end
               `TXBP_ST_HELD: begin
                  if (txg_ff[p] && (rot_ff[p] || !txg_d_ff[p] || pwcnt_ff[p] == 16'h0000)) begin
                     // Hold until the DACs are powered back on when masked.
                     if (pwcnt_ff[p] == 16'h0000) begin
                        bst_ff[p] <= `TXBP_ST_UP;
                        data_hold_out[p] <= 1'b0;
                        rot_ff[p] <= 1'b0;
                     end
                  end
               end
               default: begin
                  if (!txg_ff[p]) begin
                     // A fall during the ramp up must hold and flush just like from normal.
                     bst_ff[p] <= `TXBP_ST_DOWN;
                     data_hold_out[p] <= 1'b1;
                  end
                  else if (gset_ff[p] - gain_ff[p] <= up_ff[p]) begin
                     gain_ff[p] <= gset_ff[p];
                     bst_ff[p] <= `TXBP_ST_NORMAL;
                     done_ff[p] <= 1'b1;
                  end else
                     gain_ff[p] <= gain_ff[p] + up_ff[p];
               end
            endcase

            // Guard pin: OR of selected sources, high when valid unless inverted.
            guard_output_pin_out[p] <= cfg_ff[p][`TXBP_BIT_INVERT] ^ ~(
               (sel_ff[p][`TXBP_BIT_SEL_PWR] & pws2_ff[p]) |
               (sel_ff[p][`TXBP_BIT_SEL_TX] & ~txg_ff[p]) |
               (sel_ff[p][`TXBP_BIT_SEL_SW] & sel_ff[p][`TXBP_BIT_SW_GUARD]));
         end
         gain_out <= {gain_ff[1], gain_ff[0]};
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   // Status shows the latched source when enabled; otherwise only the power bit shows its live detector level.
   always @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         if (addr_in == `TXBP_ADDR_PAGE) rdata_out <= {6'h00, page_ff};
         else if (addr_in == `TXBP_ADDR_IRQ_EN_A) rdata_out <= irq_en_ff[0];
         else if (addr_in == `TXBP_ADDR_IRQ_EN_B) rdata_out <= irq_en_ff[1];
         else if (addr_in == `TXBP_ADDR_IRQ_ST_A)
            rdata_out <= (irq_src_ff[0] & irq_en_ff[0]) |
                         ({pws2_ff[0], 7'h00} & ~irq_en_ff[0]);
         else if (addr_in == `TXBP_ADDR_IRQ_ST_B)
            rdata_out <= (irq_src_ff[1] & irq_en_ff[1]) |
                         ({pws2_ff[1], 7'h00} & ~irq_en_ff[1]);
         else if (addr_in == `TXBP_ADDR_PD_MASK) rdata_out <= mask_ff;
         else if (addr_in == `TXBP_ADDR_GUARD_SEL) rdata_out <= sel_ff[pg ? 0 : 1];
         else if (addr_in == `TXBP_ADDR_SEQ_CFG) rdata_out <= cfg_ff[pg ? 0 : 1];
         else if (addr_in == `TXBP_ADDR_RISE0) rdata_out <= rise0_ff[pg ? 0 : 1];
         else if (addr_in == `TXBP_ADDR_RISE1) rdata_out <= rise1_ff[pg ? 0 : 1];
         else if (addr_in == `TXBP_ADDR_FALL0) rdata_out <= fall0_ff[pg ? 0 : 1];
         else if (addr_in == `TXBP_ADDR_FALL1) rdata_out <= fall1_ff[pg ? 0 : 1];
         else if (addr_in == `TXBP_ADDR_UP_LO) rdata_out <= up_ff[pg ? 0 : 1][7:0];
         else if (addr_in == `TXBP_ADDR_UP_HI) rdata_out <= up_ff[pg ? 0 : 1][15:8];
         else if (addr_in == `TXBP_ADDR_DN_LO) rdata_out <= dn_ff[pg ? 0 : 1][7:0];
         else if (addr_in == `TXBP_ADDR_DN_HI) rdata_out <= dn_ff[pg ? 0 : 1][15:8];
         else if (addr_in == `TXBP_ADDR_GAIN_LO) rdata_out <= gset_ff[pg ? 0 : 1][7:0];
         else if (addr_in == `TXBP_ADDR_GAIN_HI) rdata_out <= gset_ff[pg ? 0 : 1][15:8];
         else if (addr_in == `TXBP_ADDR_BLANK_ST)
            rdata_out <= {bst_ff[pg ? 0 : 1], 6'h00};
         else rdata_out <= 8'h00;
      end else begin
         rdata_out <= 8'h00;
      end
   end

endmodule
`default_nettype wire

// ### dv/txbp_chk_sva.sv
// Port checker for the transmit blanking and guard block.
`timescale 1ns/1ps
`default_nettype none
module txbp_chk (
   input wire clock_in, // Clock.
   input wire rstn_in, // Reset, active low.
   input wire rd_in, // Read strobe.
   input wire wr_in, // Write strobe.
   input wire [7:0] rdata_out, // Read data.
   input wire [1:0] transmit_enable_in, // Enable pins.
   input wire [1:0] pair_powerdown_out, // Pair power down.
   input wire [1:0] data_hold_out, // Hold and flush.
   input wire [31:0] gain_out, // Ramped gains.
   input wire irq_n_out // Interrupt, active low.
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   // Read data may only show in the slot after a read.
   a_rdata_slot: assert property (!rd_in |=> rdata_out == 8'h00)
      else $error("read data outside its slot");
   // A latched interrupt only drops on a register write.
   a_irq_hold: assert property (!irq_n_out && !wr_in |=> !irq_n_out)
      else $error("interrupt released without a write");
   // While held, gain may only fall, so the flush never adds amplitude.
   a_hold_gain_a: assert property (data_hold_out[0] && $past(data_hold_out[0])
      |-> gain_out[15:0] <= $past(gain_out[15:0]))
      else $error("pair A gain rose while held");
   a_hold_gain_b: assert property (data_hold_out[1] && $past(data_hold_out[1])
      |-> gain_out[31:16] <= $past(gain_out[31:16]))
      else $error("pair B gain rose while held");
   // Power down follows a low enable, seen through the input synchroniser.
   a_pd_cause_a: assert property ($rose(pair_powerdown_out[0])
      |-> !$past(transmit_enable_in[0], 2))
      else $error("pair A powered down with enable high");
   a_pd_cause_b: assert property ($rose(pair_powerdown_out[1])
      |-> !$past(transmit_enable_in[1], 2))
      else $error("pair B powered down with enable high");
   a_pd_release_a: assert property ($fell(pair_powerdown_out[0])
      |-> $past(transmit_enable_in[0], 2))
      else $error("pair A powered up with enable low");
   // Releasing the hold starts a ramp upward.
   a_ramp_up_a: assert property ($fell(data_hold_out[0])
      |=> gain_out[15:0] >= $past(gain_out[15:0]))
      else $error("pair A gain fell after release");
   c_pd: cover property ($rose(pair_powerdown_out[1]));
   c_irq: cover property ($fell(irq_n_out));
   c_release: cover property ($fell(data_hold_out[0]));
endmodule
bind txbp_top txbp_chk u_chk (.clock_in(clock_in), .rstn_in(rstn_in), .rd_in(rd_in),
   .wr_in(wr_in), .rdata_out(rdata_out), .transmit_enable_in(transmit_enable_in),
   .pair_powerdown_out(pair_powerdown_out), .data_hold_out(data_hold_out),
   .gain_out(gain_out), .irq_n_out(irq_n_out));
`default_nettype wire

// ### dv/txbp_pa_model.sv
// Enable source and power amplifier facing the guard block.
`timescale 1ns/1ps
`default_nettype none
module txbp_pa_model (
   input wire logic clock_in, // Clock.
   input wire logic [1:0] en_cmd_in, // Requested enable levels.
   input wire logic [1:0] pwr_cmd_in, // Requested over-power levels.
   input wire logic [1:0] guard_pin_in, // Guard pins from the block.
   output logic [1:0] transmit_enable_out, // Enable pins.
   output logic [1:0] power_over_out, // Detector levels.
   output logic [1:0] pa_on_out // Amplifier running.
);
   logic [1:0] en_ff = 2'h0;
   logic [1:0] pwr_ff = 2'h0;
   // Levels move just after an edge; gain is never disabled, so enable may toggle.
   always @(posedge clock_in) begin
      en_ff <= en_cmd_in;
      pwr_ff <= pwr_cmd_in;
   end
   // The amplifier runs only while its pin reports valid output.
   assign transmit_enable_out = en_ff;
   assign power_over_out = pwr_ff;
   assign pa_on_out = guard_pin_in;
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the transmit blanking and guard block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [11:0] addr_in = 12'h000;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic sync_rotate_in = 1'b0;
   logic [1:0] en_cmd = 2'h0;
   logic [1:0] pwr_cmd = 2'h0;
   logic [7:0] rv;
   wire [7:0] rdata_out;
   wire [1:0] transmit_enable_in, power_over_in, guard_output_pin_out, pair_powerdown_out;
   wire [1:0] data_hold_out, pa_on;
   wire [31:0] gain_out;
   wire irq_n_out;
   int err_total = 0;
   int tests_run = 0;
   // Short power-up wait keeps the run brief.
   txbp_top #(.PWRUP_CYC(8)) DUT (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .transmit_enable_in(transmit_enable_in), .power_over_in(power_over_in),
      .sync_rotate_in(sync_rotate_in), .guard_output_pin_out(guard_output_pin_out),
      .pair_powerdown_out(pair_powerdown_out), .data_hold_out(data_hold_out),
      .gain_out(gain_out), .irq_n_out(irq_n_out));
   txbp_pa_model u_pa (.clock_in(clock_in), .en_cmd_in(en_cmd), .pwr_cmd_in(pwr_cmd),
      .guard_pin_in(guard_output_pin_out), .transmit_enable_out(transmit_enable_in),
      .power_over_out(power_over_in), .pa_on_out(pa_on));
   always #50 clock_in = ~clock_in;
   // Bus and compare helpers.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 rv = rdata_out;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   // Paged registers, reset state and an unmapped address.
   task automatic t_regs;
      rd(12'h147);
      chk(rv[7:6], 2'b00);
      wr(12'h008, 8'h01);
      wr(12'h141, 8'h20);
      wr(12'h143, 8'h20);
      wr(12'h121, 8'h02);
      wr(12'h013, 8'h20);
      wr(12'h021, 8'h20);
      wr(12'h008, 8'h02);
      wr(12'h141, 8'h40);
      rd(12'h141);
      chk(rv, 8'h40);
      wr(12'h008, 8'h01);
      rd(12'h141);
      chk(rv, 8'h20);
      rd(12'h0FF);
      chk(rv, 8'h00);
   endtask
   // Enable rise with a 64-cycle rise delay, then a sync rotation.
   task automatic t_rise;
      @(posedge clock_in);
      en_cmd <= 2'b01;
      cyc(40);
      chk(guard_output_pin_out[0], 1'b0);
      for (int i = 0; i < 200 && data_hold_out[0] !== 1'b0; i++) @(posedge clock_in);
      chk(guard_output_pin_out[0], 1'b1);
      cyc(20);
      chk(gain_out[15:0], 16'h8000);
      chk(irq_n_out, 1'b0);
      rd(12'h147);
      chk(rv[7:6], 2'b11);
      @(posedge clock_in);
      sync_rotate_in <= 1'b1;
      @(posedge clock_in);
      sync_rotate_in <= 1'b0;
      cyc(3);
      chk(gain_out[15:0] < 16'h8000, 1'b1);
      cyc(30);
      chk(gain_out[15:0], 16'h8000);
      rd(12'h025);
      chk(rv[5], 1'b1);
      wr(12'h025, 8'h20);
      cyc(2);
      chk(irq_n_out, 1'b1);
   endtask
   // Masked enable fall: early power down, late hold, ramp to zero, then wake.
   task automatic t_fall;
      wr(12'h012, 8'h01);
      @(posedge clock_in);
      en_cmd <= 2'b00;
      cyc(500);
      chk(data_hold_out[0], 1'b0);
      for (int i = 0; i < 200 && data_hold_out[0] !== 1'b1; i++) @(posedge clock_in);
      chk(data_hold_out[0], 1'b1);
      cyc(6);
      chk(gain_out[15:0], 16'h0000);
      chk(pair_powerdown_out[0], 1'b1);
      chk(guard_output_pin_out[0], 1'b0);
      @(posedge clock_in);
      en_cmd <= 2'b01;
      cyc(90);
      chk(pair_powerdown_out[0], 1'b0);
      chk(gain_out[15:0], 16'h8000);
      wr(12'h025, 8'h20);
   endtask
   // Pair B: masked power down, power guard route, inversion, software guard.
   task automatic t_pwr;
      wr(12'h012, 8'h03);
      @(posedge clock_in);
      en_cmd <= 2'b11;
      cyc(100);
      en_cmd <= 2'b01;
      cyc(700);
      chk(pair_powerdown_out, 2'b10);
      wr(12'h008, 8'h02);
      wr(12'h013, 8'h40);
      wr(12'h022, 8'h80);
      cyc(4);
      chk(guard_output_pin_out[1], 1'b1);
      pwr_cmd <= 2'b10;
      cyc(6);
      chk(pa_on, 2'b01);
      chk(irq_n_out, 1'b0);
      wr(12'h11F, 8'h54);
      cyc(3);
      chk(guard_output_pin_out[1], 1'b1);
      wr(12'h11F, 8'h50);
      pwr_cmd <= 2'b00;
      wr(12'h013, 8'h0C);
      wr(12'h026, 8'h80);
      cyc(3);
      chk(guard_output_pin_out[1], 1'b0);
      chk(irq_n_out, 1'b1);
   endtask
   // One exit for both verdicts.
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Main sequence after 20 cycles of reset.
   initial begin
      cyc(20);
      rstn_in <= 1'b1;
      t_regs();
      t_rise();
      t_fall();
      t_pwr();
      conclude();
   end
   // The scenarios need about 1700 cycles; a hang is cut well beyond that.
   initial begin
      cyc(20000);
      err_total++;
      conclude();
   end
endmodule
`default_nettype wire
